/* File: testbench/cml_loader_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// One host bus feeds both ends; the owner of each read answer is checked
module cml_loader_tb;
    localparam logic [95:0] ID_TAB = {32'h49504148, cml_pkg::CML_ID_MAKER, 40'h0, 8'h0C, 8'h00};
    localparam int          START  = 5000 / 8;
    logic       clk_i;
    logic       arst_n_i;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       id_sel = 1'b0;
    logic [7:0] l_rdata, a_rdata;
    logic       l_ack, a_ack, a_ack_oe, l_oe, a_oe, l_mode, a_done;
    int         mismatches = 0;
    int         checks_done = 0;
    int         cyc = 0;
    cml_if cfg_bus ();
    cml_loader i_cml_loader (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg(cfg_bus), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .id_sel_i(id_sel), .rdata_o(l_rdata),
        .ack_o(l_ack), .data_oe_o(l_oe), .cfg_mode_o(l_mode));
    cml_array i_cml_array (.clk_i(clk_i), .arst_n_i(arst_n_i), .cfg(cfg_bus), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .id_sel_i(id_sel), .rdata_o(a_rdata),
        .ack_o(a_ack), .ack_oe_o(a_ack_oe), .data_oe_o(a_oe), .configured_o(a_done));
    cml_properties i_cml_properties (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .id_sel_i(id_sel), .mode_sel_i(cfg_bus.mode_sel),
        .cfg_start_i(cfg_bus.cfg_start), .cfg_data_i(cfg_bus.cfg_data),
        .cfg_data_stb_i(cfg_bus.cfg_data_stb),
        .loader_error_status_i(cfg_bus.loader_error_status),
        .load_complete_flag_i(cfg_bus.load_complete_flag));
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus_wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        id_sel <= 1'b0;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    // Answer stands only in the cycle after the strobe, so look there
    task automatic bus_rd(input logic [6:0] a, input logic id, input logic usr,
                          output logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        id_sel <= id;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = usr ? a_rdata : l_rdata;
        check({l_ack, l_oe, a_ack, a_ack_oe, a_oe}, usr ? 5'h07 : 5'h18);
    endtask
    task automatic t_id(input logic usr);
        logic [7:0] d;
        logic [7:0] e;
        for (int i = 0; i < 12; i++)
        begin
            e = ID_TAB[95 - 8 * i -: 8];
            if (i == 5)
                e = usr ? cml_pkg::CML_ID_MODEL_USR : cml_pkg::CML_ID_MODEL_CFG;
            if (i == 11)
                e = usr ? 8'h2E : 8'h4F;
            bus_rd(7'(2 * i + 1), 1'b1, usr, d);
            check(d, e);
        end
        // Even bytes and the unused tail read as zero in either mode
        bus_rd(7'h0A, 1'b1, usr, d);
        check(d, 8'h00);
        bus_rd(7'h19, 1'b1, usr, d);
        check(d, 8'h00);
    endtask
    task automatic t_start();
        logic [7:0] d;
        int         t0;
        bus_wr(7'h01, 8'h01);
        t0 = cyc;
        bus_rd(7'h01, 1'b0, 1'b0, d);
        check(d[2:0], 3'h2);
        while (d[0] !== 1'b1 && cyc < t0 + 1000)
            bus_rd(7'h01, 1'b0, 1'b0, d);
        check(cyc - t0 >= START && cyc - t0 < START + 6, 1'b1);
        check(d[2:1], 2'h1);
    endtask
    // Awkward case: a hand-back write with bit 0 low must not move the mode
    task automatic t_modes();
        logic [7:0] d;
        bus_wr(7'h03, 8'h12);
        bus_wr(7'h03, 8'hA5);
        check(a_done, 1'b0);
        bus_wr(7'h03, 8'hFF);
        repeat (4) @(posedge clk_i);
        #1;
        check({l_mode, a_done}, 2'h1);
        t_id(1'b1);
        bus_wr(7'h00, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        check(l_mode, 1'b0);
        bus_wr(7'h00, 8'h01);
        repeat (4) @(posedge clk_i);
        #1;
        check(l_mode, 1'b1);
        // Back in configuration mode the array must ignore a clearing write
        bus_wr(7'h00, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        check(l_mode, 1'b1);
        bus_rd(7'h0B, 1'b1, 1'b0, d);
        check(d, cml_pkg::CML_ID_MODEL_CFG);
    endtask
    initial
    begin
        arst_n_i = 1'b0;
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        check(l_mode, 1'b1);
        t_id(1'b0);
        t_start();
        t_modes();
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: testbench/cml_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// Ties the array port and the mode line to the host strobes
module cml_properties
(
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       id_sel_i,
    input wire logic       mode_sel_i,
    input wire logic       cfg_start_i,
    input wire logic [7:0] cfg_data_i,
    input wire logic       cfg_data_stb_i,
    input wire logic       loader_error_status_i,
    input wire logic       load_complete_flag_i
);
    logic [2:0] hist_q;
    logic       io_wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // The loader sees the line late, so only judge it once steady
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            hist_q <= 3'h0;
        else
            hist_q <= {hist_q[1:0], mode_sel_i};
    end
    assign io_wr = wr_i && !id_sel_i;
    a_start_pulse: assert property (io_wr && addr_i == 7'h01 && wdata_i[0] && &hist_q
        |=> cfg_start_i) else $error("no start pulse");
    a_byte_pass: assert property (io_wr && addr_i == 7'h03 && &hist_q
        |=> cfg_data_stb_i && cfg_data_i == $past(wdata_i)) else $error("byte not passed");
    a_no_stray_byte: assert property (cfg_data_stb_i
        |-> $past(io_wr) && $past(addr_i) == 7'h03) else $error("stray byte");
    a_idle_in_user: assert property (!mode_sel_i && hist_q == 3'h0
        |-> !cfg_data_stb_i && !cfg_start_i) else $error("loader active in user mode");
    a_busy_not_done: assert property (cfg_start_i |=> !load_complete_flag_i)
        else $error("done during load");
    a_error_line: assert property (mode_sel_i |-> loader_error_status_i)
        else $error("error line low");
    a_end_hands_over: assert property (cfg_data_stb_i && cfg_data_i == 8'hFF
        |-> ##[1:3] !mode_sel_i && load_complete_flag_i) else $error("no hand over");
    a_user_held: assert property (!mode_sel_i && !(io_wr && addr_i == 7'h00 && wdata_i[0])
        |=> !mode_sel_i) else $error("mode line moved");
    a_user_handback: assert property (!mode_sel_i && io_wr && addr_i == 7'h00 && wdata_i[0]
        |-> ##[1:2] mode_sel_i) else $error("no hand back");
endmodule
`default_nettype wire

/* File: verilog/cml_array.sv */
`timescale 1ns/100ps
`default_nettype none
// Programmable array end: owns the mode line and the bus in user mode
module cml_array
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    cml_if.array            cfg,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       id_sel_i,
    output logic [7:0]      rdata_o,
    output logic            ack_o,
    output logic            ack_oe_o,
    output logic            data_oe_o,
    output logic            configured_o
);
    typedef struct packed {
        logic       mode;
        logic       loading;
        logic       done;
        logic [7:0] rdata;
        logic       ack;
        logic       oe;
    } cml_state_s;
    cml_state_s s_q;
    cml_state_s s_d;
    logic       user_mode;

    // The array owns the bus only once it is loaded and its mode register is low
    assign user_mode = s_q.done & ~s_q.mode;

    function automatic logic [7:0] id_byte(input logic [5:0] a, input logic usr);
        unique case (a)
            6'h01: id_byte = 8'h49;
            6'h03: id_byte = 8'h50;
            6'h05: id_byte = 8'h41;
            6'h07: id_byte = 8'h48;
            6'h09: id_byte = cml_pkg::CML_ID_MAKER;
            6'h0B: id_byte = usr ? cml_pkg::CML_ID_MODEL_USR : cml_pkg::CML_ID_MODEL_CFG;
            6'h15: id_byte = cml_pkg::CML_ID_COUNT;
            6'h17: id_byte = usr ? cml_pkg::CML_ID_CHECK_USR : cml_pkg::CML_ID_CHECK_CFG;
            default: id_byte = 8'h00;
        endcase
    endfunction

    // Mode register, load emulation and user-mode bus answer
    always_comb
    begin
        s_d       = s_q;
        s_d.ack   = 1'b0;
        s_d.oe    = 1'b0;
        if (cfg.cfg_start)
        begin
            s_d.loading = 1'b1;
            s_d.done    = 1'b0;
        end
        if (s_q.loading && cfg.cfg_data_stb && cfg.cfg_data == 8'hFF)
        begin
            s_d.loading = 1'b0;   // Terminator byte completes the image
            s_d.done    = 1'b1;
            s_d.mode    = 1'b0;
        end
        // Writes ignored while mode line high
        if (user_mode && wr_i && !id_sel_i && addr_i == cml_pkg::CML_OFS_USER_CTRL)
            s_d.mode = wdata_i[0];
        if (user_mode && (rd_i || wr_i))
        begin
            s_d.ack   = 1'b1;
            s_d.oe    = rd_i;
            s_d.rdata = id_sel_i ? id_byte(addr_i[5:0], 1'b1) : {7'h00, s_q.mode};
        end
    end

    // Reset clears the mode register; the line is driven high while done is low, until loaded.
    // Limitation: this model forgets its image on reset, so it restarts unloaded.
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_q <= '{mode: cml_pkg::CML_MODE_RST, loading: 1'b0, done: 1'b0,
                     rdata: 8'h00, ack: 1'b0, oe: 1'b0};
        else
            s_q <= s_d;
    end

    assign cfg.mode_sel            = ~user_mode;
    assign cfg.loader_error_status = 1'b1;
    assign cfg.load_complete_flag  = s_q.done;
    assign rdata_o      = s_q.rdata;
    assign ack_o        = s_q.ack;
    assign ack_oe_o     = s_q.ack;
    assign data_oe_o    = s_q.oe;
    assign configured_o = s_q.done;
endmodule
`default_nettype wire

/* File: verilog/cml_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Mode line and array configuration port between loader and array
interface cml_if;
    logic       mode_sel;          // High: configuration mode
    logic       cfg_start;         // Loader asks array to begin a load
    logic [7:0] cfg_data;          // Parallel configuration byte
    logic       cfg_data_stb;      // One-cycle byte strobe
    logic       loader_error_status;
    logic       load_complete_flag;
    modport loader (output cfg_start, output cfg_data, output cfg_data_stb,
                    input mode_sel, input loader_error_status, input load_complete_flag);
    modport array  (input cfg_start, input cfg_data, input cfg_data_stb,
                    output mode_sel, output loader_error_status, output load_complete_flag);
endinterface
`default_nettype wire

/* File: verilog/cml_loader.sv */
`timescale 1ns/100ps
`default_nettype none
// Configuration loader: answers the host bus while the mode line is high
module cml_loader
(
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    cml_if.loader           cfg,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       id_sel_i,
    output logic [7:0]      rdata_o,
    output logic            ack_o,
    output logic            data_oe_o,
    output logic            cfg_mode_o
);
    typedef enum logic [1:0] {
        CML_IDLE = 2'b01,
        CML_WAIT = 2'b10
    } cml_phase_e;

    typedef struct packed {
        cml_phase_e phase;
        logic [9:0] cnt;
        logic       ready;
        logic       start;
        logic [7:0] data;
        logic       stb;
        logic [7:0] rdata;
        logic       ack;
        logic       oe;
        logic       m1;
        logic       m2;
        logic       e1;
        logic       e2;
        logic       c1;
        logic       c2;
    } cml_state_s;
    cml_state_s s_q;
    cml_state_s s_d;

    function automatic logic [7:0] id_byte(input logic [5:0] a, input logic usr);
        unique case (a)
            6'h01: id_byte = 8'h49;
            6'h03: id_byte = 8'h50;
            6'h05: id_byte = 8'h41;
            6'h07: id_byte = 8'h48;
            6'h09: id_byte = cml_pkg::CML_ID_MAKER;
            6'h0B: id_byte = usr ? cml_pkg::CML_ID_MODEL_USR : cml_pkg::CML_ID_MODEL_CFG;
            6'h15: id_byte = cml_pkg::CML_ID_COUNT;
            6'h17: id_byte = usr ? cml_pkg::CML_ID_CHECK_USR : cml_pkg::CML_ID_CHECK_CFG;
            default: id_byte = 8'h00; // Even and unused bytes
        endcase
    endfunction

    always_comb
    begin
        s_d       = s_q;
        s_d.start = 1'b0;
        s_d.stb   = 1'b0;
        s_d.ack   = 1'b0;
        s_d.oe    = 1'b0;
        // Array status lines are asynchronous to the bus clock
        s_d.m1 = cfg.mode_sel;
        s_d.m2 = s_q.m1;
        s_d.e1 = cfg.loader_error_status;
        s_d.e2 = s_q.e1;
        s_d.c1 = cfg.load_complete_flag;
        s_d.c2 = s_q.c1;
        unique case (s_q.phase)
            CML_IDLE:
                if (s_q.cnt != 10'h000)
                    s_d.cnt = s_q.cnt - 10'h001;
            CML_WAIT:
                if (s_q.cnt == 10'h001)
                begin
                    s_d.ready = 1'b1;
                    s_d.phase = CML_IDLE;
                    s_d.cnt   = 10'h000;
                end
                else
                    s_d.cnt = s_q.cnt - 10'h001;
            default:
                s_d.phase = CML_IDLE;
        endcase
        if (s_q.m2 && (rd_i || wr_i))
        begin
            s_d.ack = 1'b1;
            s_d.oe  = rd_i;
            if (id_sel_i)
                s_d.rdata = id_byte(addr_i[5:0], 1'b0);
            else if (addr_i == cml_pkg::CML_OFS_CTRL_STAT)
                s_d.rdata = {5'h00, s_q.c2, s_q.e2, s_q.ready};
            else
                s_d.rdata = 8'h00;
            if (wr_i && !id_sel_i && addr_i == cml_pkg::CML_OFS_CTRL_STAT)
            begin
                s_d.ready = 1'b0;
                if (wdata_i[cml_pkg::CML_BIT_START])
                begin
                    s_d.start = 1'b1;
                    s_d.phase = CML_WAIT;
                    s_d.cnt   = cml_pkg::CML_START_CNT;
                end
            end
            if (wr_i && !id_sel_i && addr_i == cml_pkg::CML_OFS_DATA_PORT)
            begin
                s_d.data = wdata_i;
                s_d.stb  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s_q <= '{phase: CML_IDLE, cnt: 10'h000, ready: 1'b0, start: 1'b0, data: 8'h00,
                     stb: 1'b0, rdata: 8'h00, ack: 1'b0, oe: 1'b0, m1: 1'b0, m2: 1'b0,
                     e1: 1'b0, e2: 1'b0, c1: 1'b0, c2: 1'b0};
        else
            s_q <= s_d;
    end

    assign cfg.cfg_start    = s_q.start;
    assign cfg.cfg_data     = s_q.data;
    assign cfg.cfg_data_stb = s_q.stb;
    assign rdata_o    = s_q.rdata;
    assign ack_o      = s_q.ack;
    assign data_oe_o  = s_q.oe;
    assign cfg_mode_o = s_q.m2;
endmodule
`default_nettype wire

/* File: verilog/cml_pkg.sv */
// Behaviour
// - Power-up starts in configuration mode
// - Mode line low is user mode, high configuration
// - Host starts load by writing control bit 0
// - Start bit reads high 5 us later
// - Status bit 1 mirrors array error status
// - Status bit 2 mirrors load complete
// - Host writes image bytes to data port
// - Passive parallel asynchronous load over bus only
// - Configured logic drives mode line low
// - User mode register reset-cleared, held otherwise
// - Write offset 0 bit 0 returns to configuration
// - Configuration mode: array releases ack, data, writes
// - Model code differs between modes
// - Check byte 4F config, 2E user
// - Other identification bytes mode-independent
// - Identification space odd bytes of 64-byte block
// - Identification reads take zero wait states
// - Identification map contents fixed as tabulated
// - Bus reset drives mode line high
package cml_pkg;
    // Host bus decode (byte offsets, odd byte lane except user control at 0x00)
    localparam logic [6:0] CML_OFS_USER_CTRL = 7'h00;
    localparam logic [6:0] CML_OFS_CTRL_STAT = 7'h01;
    localparam logic [6:0] CML_OFS_DATA_PORT = 7'h03;
    localparam logic [5:0] CML_OFS_ID_MODEL  = 6'h0B;
    localparam logic [5:0] CML_OFS_ID_CHECK  = 6'h17;
    localparam int         CML_ID_LAST       = 6'h17;
    // Control/status field positions
    localparam int CML_BIT_START = 0;
    localparam int CML_BIT_ERR   = 1;
    localparam int CML_BIT_DONE  = 2;
    // Identification values
    localparam logic [7:0] CML_ID_MAKER      = 8'h5A; // Arbitrary value
    localparam logic [7:0] CML_ID_MODEL_CFG  = 8'h61; // Arbitrary value
    localparam logic [7:0] CML_ID_MODEL_USR  = 8'h62; // Arbitrary value
    localparam logic [7:0] CML_ID_CHECK_CFG  = 8'h4F;
    localparam logic [7:0] CML_ID_CHECK_USR  = 8'h2E;
    localparam logic [7:0] CML_ID_COUNT      = 8'h0C;
    // Start delay: 5 us at 125 MHz
    localparam int CML_CLK_MHZ     = 125;
    localparam int CML_START_US    = 5;
    localparam int CML_START_CYC   = CML_START_US * CML_CLK_MHZ;
    localparam logic [9:0] CML_START_CNT = 10'(CML_START_CYC);
    // Reset value of user-mode mode register
    localparam logic CML_MODE_RST = 1'b0;
endpackage
